//--- verilog/isp_defines.vh
// constants for the i2c serial port control and slave block
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH
// register addresses (word index on the plain port)
`define ISP_ADDR_CON1 3'h0
`define ISP_ADDR_CON2 3'h1
`define ISP_ADDR_STAT 3'h2
`define ISP_ADDR_BUF 3'h3
`define ISP_ADDR_ADDR 3'h4
`define ISP_ADDR_FLAG 3'h5
// control one fields
`define ISP_C1_WCOLL 7
`define ISP_C1_OVF 6
`define ISP_C1_EN 5
`define ISP_C1_REL 4
// control two fields
`define ISP_C2_GENERAL_CALL_ENABLE 7
`define ISP_C2_ACK_VALUE_BIT 5
`define ISP_C2_ACK_SEQUENCE_REQUEST 4
`define ISP_C2_MASTER_RECEIVE_REQUEST 3
`define ISP_C2_PEN 2
`define ISP_C2_REPEATED_START_REQUEST 1
`define ISP_C2_SEN 0
// mode codes
`define ISP_M_S10SP 4'hF
`define ISP_M_S7SP 4'hE
`define ISP_M_FWM 4'hB
`define ISP_M_HWM 4'h8
`define ISP_M_S10 4'h7
`define ISP_M_S7 4'h6
// reset values
`define ISP_RST_CON1 8'h00
`define ISP_RST_CON2 8'h00
// ten-bit header pattern
`define ISP_TEN_HDR 5'h1E
`endif

//--- verilog/isp_core.v
// i2c serial port control registers and slave receive engine
`include "isp_defines.vh"
module isp_core (
  // clock and reset
  input wire clock,
  input wire reset,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // pins
  input wire scl_in,
  input wire sda_in,
  input wire [1:0] pin_direction_bits,
  output reg scl_out,
  output reg scl_oe,
  output reg sda_out,
  output reg sda_oe,
  output reg port_owns_pins,
  // interrupt flag level
  output reg port_interrupt_flag
);
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function is_slave;
    input [3:0] m;
    begin
      is_slave = (m == `ISP_M_S10SP) || (m == `ISP_M_S7SP) ||
        (m == `ISP_M_S10) || (m == `ISP_M_S7);
    end
  endfunction
  function is_master;
    input [3:0] m;
    begin
      is_master = (m == `ISP_M_HWM) || (m == `ISP_M_FWM);
    end
  endfunction

  function reg_hit;
    input [2:0] a;
    input [2:0] idx;
    begin
      reg_hit = a == idx;
    end
  endfunction

  localparam S_IDLE = 3'h0;
  localparam S_SHIFT = 3'h1;
  localparam S_ACK = 3'h2;
  localparam S_SKIP = 3'h3;

  // ------------------------------------------------------------
  // registers and synchronisers
  // ------------------------------------------------------------
  reg [7:0] i2c_control_one;
  reg [7:0] i2c_control_two;
  reg [7:0] transfer_buffer;
  reg [7:0] shift_register;
  reg [7:0] address_reload_register;
  reg buffer_full_flag;
  reg address_update_flag;
  reg dir_read;
  reg last_was_data;
  reg seen_start;
  reg seen_stop;
  reg [1:0] scl_s;
  reg [1:0] sda_s;
  reg scl_d;
  reg sda_d;
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg is_addr;
  reg ten_hi_pending;
  reg ack_this;
  reg hold_ua;
  reg [7:0] brg_cnt;
  reg [1:0] mseq;
  wire [3:0] port_mode_select = i2c_control_one[3:0];
  wire port_enable = i2c_control_one[`ISP_C1_EN];
  wire clock_release = i2c_control_one[`ISP_C1_REL];
  wire slave_on = port_enable && is_slave(port_mode_select);
  wire master_on = port_enable && is_master(port_mode_select);
  wire ten_bit = port_mode_select == `ISP_M_S10SP || port_mode_select == `ISP_M_S10;
  wire ss_irq = port_mode_select == `ISP_M_S10SP || port_mode_select == `ISP_M_S7SP;
  wire scl_rise = scl_s[1] && !scl_d;
  wire scl_fall = !scl_s[1] && scl_d;
  wire start_cond = scl_s[1] && scl_d && !sda_s[1] && sda_d;
  wire stop_cond = scl_s[1] && scl_d && sda_s[1] && !sda_d;
  wire req_busy = |i2c_control_two[4:0] & master_on;
  wire busy = req_busy || (state != S_IDLE);
  wire wr = reg_write;
  wire rd = reg_read;
  wire buf_wr = wr && reg_hit(reg_addr, `ISP_ADDR_BUF);
  wire buf_rd = rd && reg_hit(reg_addr, `ISP_ADDR_BUF);
  wire add_wr = wr && reg_hit(reg_addr, `ISP_ADDR_ADDR);
  wire con1_wr = wr && reg_hit(reg_addr, `ISP_ADDR_CON1);
  wire con2_wr = wr && reg_hit(reg_addr, `ISP_ADDR_CON2);
  wire flag_wr = wr && reg_hit(reg_addr, `ISP_ADDR_FLAG);
  wire [7:0] next_sr = {shift_register[6:0], sda_s[1]};
  wire gc_hit = i2c_control_two[`ISP_C2_GENERAL_CALL_ENABLE] && shift_register == 8'h00;
  wire hdr_hit = shift_register[7:3] == `ISP_TEN_HDR &&
    shift_register[2:1] == address_reload_register[2:1] && !shift_register[0];
  wire seven_hit = shift_register[7:1] == address_reload_register[7:1];
  wire lo_hit = shift_register == address_reload_register;
  wire brg_tick = brg_cnt == 8'h00;

  // ------------------------------------------------------------
  // interrupt sources
  // ------------------------------------------------------------
  // master request finished on its last reload phase
  wire master_done = master_on && (|i2c_control_two[4:0]) && brg_tick && mseq == 2'h3;
  // start or stop seen in a mode that reports them
  wire bus_event = slave_on && (start_cond || stop_cond) && ss_irq;
  // ninth falling edge closes every matched byte or any byte refused on overflow or a full buffer; other unmatched addresses go to skip without it
  wire ninth_fall = slave_on && !start_cond && !stop_cond && state == S_ACK && scl_fall;
  wire irq_set = master_done || bus_event || ninth_fall;

  always @(posedge clock) begin
    if (reset) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  // ------------------------------------------------------------
  // control, status and slave engine
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      i2c_control_one <= `ISP_RST_CON1;
      i2c_control_two <= `ISP_RST_CON2;
      transfer_buffer <= 8'h00;
      shift_register <= 8'h00;
      address_reload_register <= 8'h00;
      buffer_full_flag <= 1'b0;
      address_update_flag <= 1'b0;
      dir_read <= 1'b0;
      last_was_data <= 1'b0;
      seen_start <= 1'b0;
      seen_stop <= 1'b0;
      port_interrupt_flag <= 1'b0;
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      is_addr <= 1'b0;
      ten_hi_pending <= 1'b0;
      ack_this <= 1'b0;
      hold_ua <= 1'b0;
      brg_cnt <= 8'h00;
      mseq <= 2'h0;
    end else begin
      // software writes
      if (con1_wr) begin
        i2c_control_one <= reg_wdata;
      end
      if (con2_wr) begin
        i2c_control_two[7:5] <= reg_wdata[7:5];
        if (!busy) begin
          i2c_control_two[4:0] <= reg_wdata[4:0];
        end else if (!master_on) begin
          i2c_control_two[`ISP_C2_SEN] <= reg_wdata[`ISP_C2_SEN];
        end
      end
      if (flag_wr) begin
        port_interrupt_flag <= reg_wdata[0];
      end
      if (buf_wr) begin
        if (busy && master_on) begin
          i2c_control_one[`ISP_C1_WCOLL] <= 1'b1;
        end else if (slave_on && dir_read && state == S_SHIFT) begin
          i2c_control_one[`ISP_C1_WCOLL] <= 1'b1;
        end else if (!busy) begin
          transfer_buffer <= reg_wdata;
          shift_register <= reg_wdata;
        end
      end
      if (buf_rd) begin
        buffer_full_flag <= 1'b0;
      end
      if (add_wr) begin
        address_reload_register <= reg_wdata;
        address_update_flag <= 1'b0;
        hold_ua <= 1'b0;
      end
      // hardware master sequencer: brg divides by (reload[6:0]+1), request clears on fourth tick
      if (master_on && (|i2c_control_two[4:0])) begin
        if (brg_tick) begin
          brg_cnt <= {1'b0, address_reload_register[6:0]};
          mseq <= mseq + 2'h1;
          if (mseq == 2'h3) begin
            i2c_control_two[4:0] <= 5'h00;
          end
        end else begin
          brg_cnt <= brg_cnt - 8'h01;
        end
      end else begin
        brg_cnt <= 8'h00;
        mseq <= 2'h0;
      end
      // slave engine
      if (!slave_on) begin
        state <= S_IDLE;
        hold_ua <= 1'b0;
        address_update_flag <= 1'b0;
        ten_hi_pending <= 1'b0;
        last_was_data <= 1'b0;
        seen_start <= 1'b0;
        seen_stop <= 1'b0;
      end else if (start_cond) begin
        state <= S_SHIFT;
        bit_cnt <= 4'h0;
        is_addr <= 1'b1;
        seen_start <= 1'b1;
        seen_stop <= 1'b0;
      end else if (stop_cond) begin
        state <= S_IDLE;
        seen_stop <= 1'b1;
        seen_start <= 1'b0;
        ten_hi_pending <= 1'b0;
      end else begin
        case (state)
          S_SHIFT: begin
            if (scl_rise && !dir_read) begin
              shift_register <= next_sr;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == 4'h8) begin
              state <= S_ACK;
              last_was_data <= !is_addr;
              ack_this <= 1'b0;
              if (i2c_control_one[`ISP_C1_OVF] || buffer_full_flag) begin
                if (!is_addr) i2c_control_one[`ISP_C1_OVF] <= 1'b1;
                ack_this <= 1'b0;
              end else if (!is_addr || gc_hit ||
                  (!ten_bit && seven_hit) ||
                  (ten_bit && !ten_hi_pending && hdr_hit) ||
                  (ten_bit && ten_hi_pending && lo_hit)) begin
                transfer_buffer <= shift_register;
                buffer_full_flag <= 1'b1;
                ack_this <= 1'b1;
                if (is_addr) dir_read <= shift_register[0];
                if (is_addr && ten_bit && !gc_hit) begin
                  address_update_flag <= 1'b1;
                  hold_ua <= 1'b1;
                  ten_hi_pending <= !ten_hi_pending;
                end
              end else begin
                state <= S_SKIP;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (ack_this) begin
                state <= S_SHIFT;
                if (is_addr && ten_bit && ten_hi_pending) begin
                  is_addr <= 1'b1;
                end else begin
                  is_addr <= 1'b0;
                end
                if (!is_addr && i2c_control_two[`ISP_C2_SEN] && buffer_full_flag) begin
                  i2c_control_one[`ISP_C1_REL] <= 1'b0;
                end
              end else begin
                state <= is_addr ? S_SKIP : S_SHIFT;
              end
            end
          end
          S_SKIP: begin
            state <= S_SKIP;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
      if (irq_set) begin
        port_interrupt_flag <= 1'b1;
      end
      if (!port_enable) begin
        seen_start <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      port_owns_pins <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      port_owns_pins <= port_enable && (slave_on || master_on);
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      if ((slave_on || master_on) && (&pin_direction_bits)) begin
        if (slave_on) begin
          scl_oe <= (!clock_release && !scl_s[1]) || hold_ua;
          sda_oe <= state == S_ACK && ack_this;
        end else begin
          scl_oe <= |i2c_control_two[4:0] && mseq[1];
          sda_oe <= i2c_control_two[`ISP_C2_ACK_SEQUENCE_REQUEST] ?
            !i2c_control_two[`ISP_C2_ACK_VALUE_BIT] :
            (i2c_control_two[`ISP_C2_REPEATED_START_REQUEST] && mseq != 2'h0);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (rd) begin
      case (reg_addr)
        `ISP_ADDR_CON1: reg_rdata <= i2c_control_one;
        `ISP_ADDR_CON2: reg_rdata <= i2c_control_two;
        `ISP_ADDR_STAT: reg_rdata <= {2'h0, last_was_data, seen_stop, seen_start,
          dir_read, address_update_flag, buffer_full_flag};
        `ISP_ADDR_BUF: reg_rdata <= transfer_buffer;
        `ISP_ADDR_ADDR: reg_rdata <= address_reload_register;
        `ISP_ADDR_FLAG: reg_rdata <= {7'h00, port_interrupt_flag};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

//--- dv/isp_core_sva.sv
// assertion checker for the i2c serial port core
module isp_core_sva (
  // clock and reset
  input logic clock,
  input logic reset,
  // register port
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_write,
  input logic reg_read,
  input logic [7:0] reg_rdata,
  // pins
  input logic scl_in,
  input logic sda_in,
  input logic [1:0] pin_direction_bits,
  input logic scl_out,
  input logic scl_oe,
  input logic sda_out,
  input logic sda_oe,
  input logic port_owns_pins,
  input logic port_interrupt_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr1;
  logic ok;
  logic fw;
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  assign wr1 = reg_write && reg_addr == 3'h0;
  assign fw = reg_write && reg_addr == 3'h5;
  assign ok = reg_wdata[5] && reg_wdata[3:0] inside {4'hF, 4'hE, 4'hB, 4'h8, 4'h7, 4'h6};
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  chk_pins_free: assert property (!port_owns_pins [*2] |-> !scl_oe && !sda_oe)
    else $error("pin pulled while port off");
  chk_mode_off: assert property (wr1 && !ok ##1 !reg_write |=> !port_owns_pins)
    else $error("port active in unlisted mode");
  chk_mode_on: assert property (wr1 && ok ##1 !reg_write |=> port_owns_pins)
    else $error("port idle in listed mode");
  chk_flag_set: assert property (fw && reg_wdata[0] |=> port_interrupt_flag)
    else $error("flag not set by write");
  chk_flag_hold: assert property (port_interrupt_flag && !fw |=> port_interrupt_flag)
    else $error("flag dropped without write");
  chk_full_clear: assert property (
    reg_read && reg_addr == 3'h3 ##2 reg_read && reg_addr == 3'h2 |=> !reg_rdata[0])
    else $error("full flag kept after buffer read");
  chk_scl_free: assert property (wr1 && reg_wdata[5:0] == 6'h36 ##1 !reg_write |-> ##[1:2] !scl_oe)
    else $error("clock held after release");
  cov_ack: cover property ($rose(sda_oe));
  cov_flag: cover property ($rose(port_interrupt_flag));
  cov_stretch: cover property (scl_oe [*8]);
endmodule
bind isp_core isp_core_sva i_sva (.clock(clock), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .scl_in(scl_in), .sda_in(sda_in), .pin_direction_bits(pin_direction_bits),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .port_owns_pins(port_owns_pins), .port_interrupt_flag(port_interrupt_flag));

//--- dv/isp_bus_master.sv
// behavioural i2c bus master on the shared lines
module isp_bus_master (
  // clock
  input logic clock,
  // resolved lines
  input logic scl,
  input logic sda,
  // line pull-downs
  output logic scl_low,
  output logic sda_low,
  // stretch wait ran out
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hung = 1'b0;
  end
  task automatic half();
    repeat (12) @(posedge clock);
  endtask
  task automatic start();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
  endtask
  task automatic bit_io(input logic b, output logic s);
    int n;
    sda_low <= !b;
    half();
    scl_low <= 1'b0;
    n = 0;
    // wait while the slave stretches
    while (!scl && n < 2000) begin
      @(posedge clock);
      n++;
    end
    if (n == 2000) hung <= 1'b1;
    half();
    s = sda;
    scl_low <= 1'b1;
  endtask
  task automatic xfer(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b0;
    half();
    sda_low <= 1'b0;
    half();
  endtask
endmodule

//--- dv/i2c_port_control_and_slave_bench.sv
// self-checking bench for the i2c port control and slave core
module i2c_port_control_and_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, reg_write, reg_read, m_scl, m_sda, hung;
  logic scl_oe, sda_oe, own, irq, scl, sda;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, sa;
  logic [7:0] q[$];
  int error_cnt, n_compared, seed, ovf;
  assign scl = !(scl_oe || m_scl);
  assign sda = !(sda_oe || m_sda);
  isp_core i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl),
    .sda_in(sda), .pin_direction_bits(2'h3), .scl_out(), .scl_oe(scl_oe), .sda_out(),
    .sda_oe(sda_oe), .port_owns_pins(own), .port_interrupt_flag(irq));
  isp_bus_master i_mst (.clock(clock), .scl(scl), .sda(sda), .scl_low(m_scl),
    .sda_low(m_sda), .hung(hung));
  //----------------
  // tasks
  //----------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    chk(reg_rdata & m, e);
  endtask
  task automatic rdbuf();
    rc(3'h3, 8'hFF, q.pop_front());
    rc(3'h2, 8'h01, 8'h00);
  endtask
  task automatic sb(input logic [7:0] b, input logic hit, input logic dat);
    logic ack;
    logic acc;
    wr(3'h5, 8'h00);
    acc = hit && q.size() == 0 && ovf == 0;
    i_mst.xfer(b, ack);
    repeat (8) @(posedge clock);
    chk({7'h00, ack}, {7'h00, !acc});
    chk({7'h00, irq}, {7'h00, hit});
    if (acc) q.push_back(b);
    if (hit && dat && !acc) ovf = 1;
    if (acc) rc(3'h2, 8'h25, {2'b00, dat, 5'h01});
  endtask
  task automatic poll();
    logic [7:0] r;
    r = 8'hFF;
    for (int n = 0; n < 500 && r[4:0] != 5'h00; n++) begin
      reg_addr <= 3'h1;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
      r = reg_rdata;
    end
    chk(r & 8'h1F, 8'h00);
  endtask
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //----------------
  // stimulus
  //----------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    seed = 32'hA525;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rc(3'h0, 8'hFF, 8'h00);
    rc(3'h1, 8'hFF, 8'h00);
    rc(3'h7, 8'hFF, 8'h00);
    wr(3'h5, 8'h01);
    chk({7'h00, irq}, 8'h01);
    for (int i = 0; i < 17; i++) begin
      wr(3'h0, i < 16 ? 8'h30 | 8'(i) : 8'h16);
      @(posedge clock);
      chk({7'h00, own}, {7'h00, i < 16 && i[3:0] inside {4'hF, 4'hE, 4'hB, 4'h8, 4'h7, 4'h6}});
    end
    sa = {1'b1, 6'($random(seed)), 1'b0};
    wr(3'h4, sa);
    wr(3'h0, 8'h36);
    i_mst.start();
    sb(sa, 1'b1, 1'b0);
    rdbuf();
    sb(8'($random(seed)), 1'b1, 1'b1);
    sb(8'($random(seed)), 1'b1, 1'b1);
    i_mst.stop();
    rc(3'h0, 8'h40, 8'h40);
    rdbuf();
    wr(3'h0, 8'h36);
    ovf = 0;
    rc(3'h0, 8'h40, 8'h00);
    i_mst.start();
    sb(sa ^ 8'h02, 1'b0, 1'b0);
    i_mst.stop();
    wr(3'h1, 8'h01);
    i_mst.start();
    sb(sa, 1'b1, 1'b0);
    rdbuf();
    sb(8'($random(seed)), 1'b1, 1'b1);
    chk({7'h00, scl_oe}, 8'h01);
    rc(3'h0, 8'h10, 8'h00);
    wr(3'h0, 8'h36);
    repeat (2) @(posedge clock);
    chk({7'h00, scl_oe}, 8'h00);
    rdbuf();
    i_mst.stop();
    wr(3'h1, 8'h80);
    i_mst.start();
    sb(8'h00, 1'b1, 1'b0);
    rdbuf();
    i_mst.stop();
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h10);
    wr(3'h0, 8'h28);
    for (int b = 0; b < 5; b++) begin
      wr(3'h1, 8'h01 << b);
      poll();
    end
    wr(3'h1, 8'h04);
    wr(3'h1, 8'h02);
    wr(3'h3, 8'hA5);
    rc(3'h1, 8'h1F, 8'h04);
    rc(3'h0, 8'h80, 8'h80);
    poll();
    chk({7'h00, hung}, 8'h00);
    summarize();
  end
endmodule
